/* logic/dcr_pkg.sv */
// constants for the deserializer control register bank
// assumes a byte-wide register space reached over an smbus target port
package dcr_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_MODE = 8'h21;
  localparam logic [7:0] ADDR_OVR  = 8'h22;
  localparam logic [7:0] ADDR_LVDS = 8'h27;

  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] CTRL_MASK = 8'h07;
  localparam logic [7:0] MODE_MASK = 8'h13;
  localparam logic [7:0] OVR_MASK  = 8'h11;
  localparam logic [7:0] LVDS_MASK = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // field positions
  localparam int CTRL_PWRDN_BIT = 0;
  localparam int CTRL_CHRST_BIT = 1;
  localparam int CTRL_ORDER_BIT = 2;
  localparam int MODE_INSEL_BIT = 4;
  localparam int OVR_MODE_BIT   = 0;
  localparam int OVR_MUX_BIT    = 4;
  localparam int LVDS_SWING_BIT = 7;
  localparam int LVDS_SMBUS_BIT = 6;
  localparam int LVDS_CLK_BIT   = 5;
  localparam int LVDS_LANE_MSB  = 4;

  localparam logic [1:0] MODE_ASI_CODE = 2'h3;
  localparam logic [5:0] ALL_DRIVERS   = 6'h3F;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] CNT_ZERO      = 4'h0;

  // smbus byte protocol states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_CMD   = 9'h008,
    ST_ACK_C = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } dcr_state_t;

endpackage : dcr_pkg

/* logic/dcr_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level; no bus coherency implied
`timescale 1ns/10ps
`default_nettype none
module dcr_sync #(
  parameter int         WIDTH = 1,
  parameter logic [3:0] INIT  = 4'h0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = d;
    next_q    = meta;
    if (!rst_n) begin
      next_meta = INIT[WIDTH-1:0];
      next_q    = INIT[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q    <= next_q;
  end

endmodule : dcr_sync
`default_nettype wire

/* logic/dcr_bus_edges.sv */
// smbus line event detector: clock edges, start and stop
// assumes scl and sda are already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module dcr_bus_edges (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic scl_rise,
  output var  logic scl_fall,
  output var  logic start,
  output var  logic stop
);

  logic scl_d;
  logic sda_d;
  logic next_scl_d;
  logic next_sda_d;
  logic next_rise;
  logic next_fall;
  logic next_start;
  logic next_stop;

  // sda moving while scl is high marks start or stop
  always_comb begin
    next_scl_d = scl;
    next_sda_d = sda;
    next_rise  = scl & ~scl_d;
    next_fall  = ~scl & scl_d;
    next_start = scl & scl_d & sda_d & ~sda;
    next_stop  = scl & scl_d & ~sda_d & sda;
    if (!rst_n) begin
      // idle-high history so no false edge follows reset
      next_scl_d = 1'b1;
      next_sda_d = 1'b1;
      next_rise  = 1'b0;
      next_fall  = 1'b0;
      next_start = 1'b0;
      next_stop  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    scl_d    <= next_scl_d;
    sda_d    <= next_sda_d;
    scl_rise <= next_rise;
    scl_fall <= next_fall;
    start    <= next_start;
    stop     <= next_stop;
  end

endmodule : dcr_bus_edges
`default_nettype wire

/* logic/dcr_top.sv */
// control register bank of a serial video deserializer with smbus target
// assumes an external smbus master and pull-ups; sda driven low only
//
// Notes on behaviour
// R1: data-order bit picks lsb-first when clear, msb-first when set.
// R2: channel-reset bit set holds the receive channel in reset.
// R3: digital power-down bit set stops digital processing sections.
// R4: mode register input-select drives the mux only while mux override set.
// R5: mux override clear lets the input-select pin drive the mux.
// R6: mode override set uses mode field, code 11 is asi; else the pin.
// R7: swing bit set gives the larger output swing.
// R8: smbus-control bit set puts each driver under its register enable.
// R9: recovered clock driver enable bit, reset zero.
// R10: lane four and three driver enable bits, reset zero.
// R11: lane two, one and zero driver enable bits, reset zero.
// R12: reserved bits read zero and writes to them do nothing.
`timescale 1ns/10ps
`default_nettype none
module dcr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2D  // arbitrary target address
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output var  logic       SDA_OUT,
  output var  logic       SDA_OE,
  input  wire logic       INPUT_SELECT_PIN,
  input  wire logic       MODE_SELECT_PIN,
  output var  logic       DATA_ORDER_MSB_FIRST,
  output var  logic       CHANNEL_RESET,
  output var  logic       DIGITAL_POWERDOWN,
  output var  logic       INPUT_SELECT,
  output var  logic       MODE_ASI,
  output var  logic       OUTPUT_SWING_BOOST,
  output var  logic       RECOVERED_CLOCK_OUTPUT_EN,
  output var  logic [4:0] DATA_LANE_EN
);

  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       pin_sel;
  logic       pin_mode;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  // bus lines idle high, strap pins idle low
  dcr_sync #(
    .WIDTH (4),
    .INIT  (4'hC)
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .d     ({SCL, SDA_IN, INPUT_SELECT_PIN, MODE_SELECT_PIN}),
    .q     (pins_s)
  );

  assign scl_s    = pins_s[3];
  assign sda_s    = pins_s[2];
  assign pin_sel  = pins_s[1];
  assign pin_mode = pins_s[0];

  dcr_bus_edges u_edges (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .scl      (scl_s),
    .sda      (sda_s),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (start),
    .stop     (stop)
  );

  logic [7:0] ctrl;
  logic [7:0] mode;
  logic [7:0] ovr;
  logic [7:0] lvds;

  // reserved positions are masked off at write time
  function automatic logic [7:0] wr_val(input logic [7:0] d, input logic [7:0] m);
    wr_val = d & m;  // [R12]
  endfunction : wr_val

  // unmapped offsets read as zero
  function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [7:0] c,
                                        input logic [7:0] md, input logic [7:0] o,
                                        input logic [7:0] l);
    case (a)
      dcr_pkg::ADDR_CTRL: rd_reg = c;
      dcr_pkg::ADDR_MODE: rd_reg = md;
      dcr_pkg::ADDR_OVR:  rd_reg = o;
      dcr_pkg::ADDR_LVDS: rd_reg = l;
      default:            rd_reg = dcr_pkg::READ_NONE;  // [R12]
    endcase
  endfunction : rd_reg

  dcr_pkg::dcr_state_t state;
  dcr_pkg::dcr_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txreg;
  logic [7:0] next_txreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       rw;
  logic       next_rw;
  logic       next_oe;
  logic       wr_stb;
  logic       next_wr_stb;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;

  // byte protocol; sda only changes after scl has fallen
  always_comb begin
    logic [7:0] rd_byte;
    rd_byte      = rd_reg(ptr, ctrl, mode, ovr, lvds);
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_txreg   = txreg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_oe      = SDA_OE;
    next_wr_stb  = 1'b0;
    next_wr_data = wr_data;
    if (start) begin
      next_state  = dcr_pkg::ST_ADDR;
      next_bitcnt = dcr_pkg::CNT_ZERO;
      next_oe     = 1'b0;
    end else if (stop) begin
      next_state = dcr_pkg::ST_IDLE;
      next_oe    = 1'b0;
    end else if (scl_rise && state != dcr_pkg::ST_IDLE) begin
      next_shreg  = {shreg[6:0], sda_s};
      next_bitcnt = bitcnt + 4'h1;
    end else if (scl_fall) begin
      case (state)
        dcr_pkg::ST_ADDR: begin
          if (bitcnt == dcr_pkg::BYTE_BITS) begin
            if (shreg[7:1] == DEV_ADDR) begin
              next_oe    = 1'b1;
              next_rw    = shreg[0];
              next_state = dcr_pkg::ST_ACK_A;
            end else begin
              next_state = dcr_pkg::ST_IDLE;  // not for us, wait for next start
            end
          end
        end
        dcr_pkg::ST_ACK_A: begin
          next_bitcnt = dcr_pkg::CNT_ZERO;
          if (rw) begin
            next_txreg = rd_byte;
            next_oe    = ~rd_byte[7];
            next_state = dcr_pkg::ST_RDATA;
          end else begin
            next_oe    = 1'b0;
            next_state = dcr_pkg::ST_CMD;
          end
        end
        dcr_pkg::ST_CMD: begin
          if (bitcnt == dcr_pkg::BYTE_BITS) begin
            next_ptr   = shreg;
            next_oe    = 1'b1;
            next_state = dcr_pkg::ST_ACK_C;
          end
        end
        dcr_pkg::ST_ACK_C, dcr_pkg::ST_ACK_W: begin
          // pointer moves only after the write strobe has been used
          if (state == dcr_pkg::ST_ACK_W) begin
            next_ptr = ptr + 8'h01;
          end
          next_oe     = 1'b0;
          next_bitcnt = dcr_pkg::CNT_ZERO;
          next_state  = dcr_pkg::ST_WDATA;
        end
        dcr_pkg::ST_WDATA: begin
          if (bitcnt == dcr_pkg::BYTE_BITS) begin
            next_wr_stb  = 1'b1;
            next_wr_data = shreg;
            next_oe      = 1'b1;
            next_state   = dcr_pkg::ST_ACK_W;
          end
        end
        dcr_pkg::ST_RDATA: begin
          if (bitcnt == dcr_pkg::BYTE_BITS) begin
            next_oe    = 1'b0;
            next_ptr   = ptr + 8'h01;
            next_state = dcr_pkg::ST_RACK;
          end else if (bitcnt != dcr_pkg::CNT_ZERO) begin
            next_txreg = {txreg[6:0], 1'b0};
            next_oe    = ~txreg[6];
          end
        end
        dcr_pkg::ST_RACK: begin
          next_bitcnt = dcr_pkg::CNT_ZERO;
          if (!shreg[0]) begin
            next_txreg = rd_byte;
            next_oe    = ~rd_byte[7];
            next_state = dcr_pkg::ST_RDATA;
          end else begin
            next_state = dcr_pkg::ST_IDLE;  // master nack ends the read
          end
        end
        default: begin
          next_state = dcr_pkg::ST_IDLE;
        end
      endcase
    end
    if (!RST_N) begin
      next_state   = dcr_pkg::ST_IDLE;
      next_bitcnt  = dcr_pkg::CNT_ZERO;
      next_shreg   = dcr_pkg::REG_RESET;
      next_txreg   = dcr_pkg::REG_RESET;
      next_ptr     = dcr_pkg::REG_RESET;
      next_rw      = 1'b0;
      next_oe      = 1'b0;
      next_wr_stb  = 1'b0;
      next_wr_data = dcr_pkg::REG_RESET;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    state   <= next_state;
    bitcnt  <= next_bitcnt;
    shreg   <= next_shreg;
    txreg   <= next_txreg;
    ptr     <= next_ptr;
    rw      <= next_rw;
    SDA_OE  <= next_oe;
    SDA_OUT <= 1'b0;  // open drain: only ever pulls low
    wr_stb  <= next_wr_stb;
    wr_data <= next_wr_data;
  end

  logic [7:0] next_ctrl;
  logic [7:0] next_mode;
  logic [7:0] next_ovr;
  logic [7:0] next_lvds;

  // register bank; writes to unmapped offsets are dropped
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_ovr  = ovr;
    next_lvds = lvds;
    if (wr_stb) begin
      case (ptr)
        dcr_pkg::ADDR_CTRL: next_ctrl = wr_val(wr_data, dcr_pkg::CTRL_MASK);  // [R1] [R2] [R3]
        dcr_pkg::ADDR_MODE: next_mode = wr_val(wr_data, dcr_pkg::MODE_MASK);  // [R4] [R6]
        dcr_pkg::ADDR_OVR:  next_ovr  = wr_val(wr_data, dcr_pkg::OVR_MASK);   // [R5]
        dcr_pkg::ADDR_LVDS: next_lvds = wr_val(wr_data, dcr_pkg::LVDS_MASK);  // [R7] [R8]
        default: begin
        end
      endcase
    end
    if (!RST_N) begin
      next_ctrl = dcr_pkg::REG_RESET;
      next_mode = dcr_pkg::REG_RESET;
      next_ovr  = dcr_pkg::REG_RESET;
      next_lvds = dcr_pkg::REG_RESET;  // [R9] [R10] [R11]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    ctrl <= next_ctrl;
    mode <= next_mode;
    ovr  <= next_ovr;
    lvds <= next_lvds;
  end

  logic       next_order;
  logic       next_chrst;
  logic       next_pwrdn;
  logic       next_insel;
  logic       next_asi;
  logic       next_swing;
  logic [5:0] next_drv;

  // control outputs, registered so that pins see no decode glitches
  always_comb begin
    next_order = ctrl[dcr_pkg::CTRL_ORDER_BIT];  // [R1]
    next_chrst = ctrl[dcr_pkg::CTRL_CHRST_BIT];  // [R2]
    next_pwrdn = ctrl[dcr_pkg::CTRL_PWRDN_BIT];  // [R3]
    next_insel = ovr[dcr_pkg::OVR_MUX_BIT] ? mode[dcr_pkg::MODE_INSEL_BIT]
                                           : pin_sel;  // [R4] [R5]
    next_asi   = ovr[dcr_pkg::OVR_MODE_BIT] ? (mode[1:0] == dcr_pkg::MODE_ASI_CODE)
                                            : pin_mode;  // [R6]
    next_swing = lvds[dcr_pkg::LVDS_SWING_BIT];  // [R7]
    // without register control every driver stays on
    next_drv   = lvds[dcr_pkg::LVDS_SMBUS_BIT] ? lvds[dcr_pkg::LVDS_CLK_BIT:0]
                                               : dcr_pkg::ALL_DRIVERS;  // [R8] [R9] [R10] [R11]
    if (!RST_N) begin
      next_order = 1'b0;
      next_chrst = 1'b0;
      next_pwrdn = 1'b0;
      next_insel = 1'b0;
      next_asi   = 1'b0;
      next_swing = 1'b0;
      next_drv   = dcr_pkg::ALL_DRIVERS;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    DATA_ORDER_MSB_FIRST      <= next_order;
    CHANNEL_RESET             <= next_chrst;
    DIGITAL_POWERDOWN         <= next_pwrdn;
    INPUT_SELECT              <= next_insel;
    MODE_ASI                  <= next_asi;
    OUTPUT_SWING_BOOST        <= next_swing;
    RECOVERED_CLOCK_OUTPUT_EN <= next_drv[dcr_pkg::LVDS_CLK_BIT];
    DATA_LANE_EN              <= next_drv[dcr_pkg::LVDS_LANE_MSB:0];
  end

  // checks on the register bank and its outputs
  sequence s_ctrl_wr;
    wr_stb && ptr == dcr_pkg::ADDR_CTRL;
  endsequence

  sequence s_unmapped_wr;
    wr_stb && ptr != dcr_pkg::ADDR_CTRL && ptr != dcr_pkg::ADDR_MODE &&
    ptr != dcr_pkg::ADDR_OVR && ptr != dcr_pkg::ADDR_LVDS;
  endsequence

  property p_order;  // [R1]
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_ctrl_wr |-> ##2 DATA_ORDER_MSB_FIRST == $past(wr_data[dcr_pkg::CTRL_ORDER_BIT], 2);
  endproperty
  a_order: assert property (p_order) else $error("data order output wrong");  // [R1]

  property p_chrst;  // [R2]
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_ctrl_wr ##1 ctrl[dcr_pkg::CTRL_CHRST_BIT] |=> CHANNEL_RESET [*1];
  endproperty
  a_chrst: assert property (p_chrst) else $error("channel reset not applied");  // [R2]

  property p_pwrdn;  // [R3]
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_ctrl_wr |-> ##2 DIGITAL_POWERDOWN == $past(wr_data[dcr_pkg::CTRL_PWRDN_BIT], 2);
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("powerdown output wrong");  // [R3]

  property p_insel_reg;  // [R4]
    @(posedge CORE_CLK) disable iff (!RST_N)
    ovr[dcr_pkg::OVR_MUX_BIT] |=> INPUT_SELECT == $past(mode[dcr_pkg::MODE_INSEL_BIT]);
  endproperty
  a_insel_reg: assert property (p_insel_reg) else $error("mux not from register");  // [R4]

  property p_insel_pin;  // [R5]
    @(posedge CORE_CLK) disable iff (!RST_N)
    !ovr[dcr_pkg::OVR_MUX_BIT] |=> INPUT_SELECT == $past(pin_sel);
  endproperty
  a_insel_pin: assert property (p_insel_pin) else $error("mux not from pin");  // [R5]

  property p_mode;  // [R6]
    @(posedge CORE_CLK) disable iff (!RST_N)
    1'b1 |=> MODE_ASI == ($past(ovr[dcr_pkg::OVR_MODE_BIT]) ?
                          ($past(mode[1:0]) == dcr_pkg::MODE_ASI_CODE) : $past(pin_mode));
  endproperty
  a_mode: assert property (p_mode) else $error("operating mode wrong");  // [R6]

  property p_swing;  // [R7]
    @(posedge CORE_CLK) disable iff (!RST_N)
    $changed(lvds[dcr_pkg::LVDS_SWING_BIT]) |=>
      OUTPUT_SWING_BOOST == $past(lvds[dcr_pkg::LVDS_SWING_BIT]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing output wrong");  // [R7]

  property p_drv_free;  // [R8]
    @(posedge CORE_CLK) disable iff (!RST_N)
    !lvds[dcr_pkg::LVDS_SMBUS_BIT] |=> RECOVERED_CLOCK_OUTPUT_EN && DATA_LANE_EN == 5'h1F;
  endproperty
  a_drv_free: assert property (p_drv_free) else $error("drivers not free running");  // [R8]

  property p_drv_reg;  // [R9] [R10] [R11]
    @(posedge CORE_CLK) disable iff (!RST_N)
    lvds[dcr_pkg::LVDS_SMBUS_BIT] |=>
      {RECOVERED_CLOCK_OUTPUT_EN, DATA_LANE_EN} == $past(lvds[5:0]);
  endproperty
  a_drv_reg: assert property (p_drv_reg) else $error("driver enables wrong");  // [R9] [R10] [R11]

  property p_reserved;  // [R12]
    @(posedge CORE_CLK) disable iff (!RST_N)
    s_unmapped_wr |=> $stable(ctrl) && $stable(mode) && $stable(ovr) && $stable(lvds) &&
      (mode & ~dcr_pkg::MODE_MASK) == 8'h00 && (ovr & ~dcr_pkg::OVR_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write took effect");  // [R12]

endmodule : dcr_top
`default_nettype wire

/* test/dcr_smbus_master.sv */
// smbus master model standing in for the host controller
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module dcr_smbus_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_pull
);
  // idle bus: both lines released, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // data moves well after the fall so the device sync sees scl low first
  task automatic bit_io(input logic b, output logic r);
    wait_n(5);
    sda_pull = ~b;
    wait_n(5);
    scl = 1'b1;
    wait_n(8);
    r = sda_line;
    wait_n(2);
    scl = 1'b0;
  endtask : bit_io

  // start, also used as repeated start from mid-frame
  task automatic start_c();
    wait_n(5);
    sda_pull = 1'b0;
    wait_n(5);
    scl = 1'b1;
    wait_n(10);
    sda_pull = 1'b1;
    wait_n(10);
    scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    wait_n(5);
    sda_pull = 1'b1;
    wait_n(5);
    scl = 1'b1;
    wait_n(10);
    sda_pull = 1'b0;
    wait_n(10);
  endtask : stop_c

  // byte out msb first, ninth clock samples the target ack
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_out

  task automatic byte_in(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
  endtask : byte_in

  task automatic write_reg(input logic [6:0] a, input logic [7:0] off,
                           input logic [7:0] dat, output logic ok);
    logic k0, k1, k2;
    start_c();
    byte_out({a, 1'b0}, k0);
    byte_out(off, k1);
    byte_out(dat, k2);
    stop_c();
    ok = k0 & k1 & k2;
  endtask : write_reg

  // pointer write, repeated start, one byte read ended by nack
  task automatic read_reg(input logic [6:0] a, input logic [7:0] off,
                          output logic [7:0] dat, output logic ok);
    logic k0, k1, k2;
    start_c();
    byte_out({a, 1'b0}, k0);
    byte_out(off, k1);
    start_c();
    byte_out({a, 1'b1}, k2);
    byte_in(1'b1, dat);
    stop_c();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : dcr_smbus_master
`default_nettype wire

/* test/tb_top.sv */
// register bank bench: smbus accesses with expected pin effects
// assumes the master model in dcr_smbus_master and a pull-up on data
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [6:0] DEV = 7'h2D;  // arbitrary target address

  logic       clk, rst_n, in_pin, mode_pin, scl, sda_pull, sda_line;
  logic       sda_out, sda_oe, order, ch_rst, pwrdn, in_sel, asi;
  logic       swing, clk_en;
  logic [4:0] lane_en;
  logic [7:0] tab [9];
  logic [7:0] v;
  logic       ok;
  int         fail_count;
  int         n_compared;

  // open-drain wire: low if either party pulls
  assign sda_line = ~(sda_pull | sda_oe);

  dcr_top #(.DEV_ADDR(DEV)) i_dcr_top (
    .CORE_CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INPUT_SELECT_PIN(in_pin),
    .MODE_SELECT_PIN(mode_pin), .DATA_ORDER_MSB_FIRST(order),
    .CHANNEL_RESET(ch_rst), .DIGITAL_POWERDOWN(pwrdn), .INPUT_SELECT(in_sel),
    .MODE_ASI(asi), .OUTPUT_SWING_BOOST(swing),
    .RECOVERED_CLOCK_OUTPUT_EN(clk_en), .DATA_LANE_EN(lane_en));

  dcr_smbus_master i_dcr_smbus_master (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // register access with the ack checked alongside
  task automatic wr(input logic [7:0] off, input logic [7:0] dat);
    i_dcr_smbus_master.write_reg(DEV, off, dat, ok);
    check({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    i_dcr_smbus_master.read_reg(DEV, off, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rd_chk

  // pins settle through two sync flops and the output flop before a look
  task automatic pins(input logic i, input logic m);
    @(negedge clk);
    in_pin = i;
    mode_pin = m;
    repeat (6) @(negedge clk);
  endtask : pins

  function automatic logic [7:0] ctrl_v();
    return {5'h00, order, ch_rst, pwrdn};
  endfunction : ctrl_v

  function automatic logic [7:0] mux_v();
    return {3'h0, in_sel, 3'h0, asi};
  endfunction : mux_v

  function automatic logic [7:0] lvds_v();
    return {swing, clk_en, 1'b0, lane_en};
  endfunction : lvds_v

  // hang guard: an exhausted limit counts as a mismatch
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h1_3880, 32'h0);
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    in_pin = 1'b0;
    mode_pin = 1'b0;
    fail_count = 0;
    n_compared = 0;
    // two edges: every flop loads a constant while reset is low
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check(ctrl_v(), 8'h00);
    check(lvds_v(), 8'h5F);
    tab[0:3] = '{8'h20, 8'h21, 8'h22, 8'h27};
    for (int i = 0; i < 4; i++) begin
      rd_chk(tab[i], 8'h00);
    end

    // control bits, reserved ones masked off
    tab[0:4] = '{8'hFF, 8'h04, 8'h02, 8'h01, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, tab[i]);
      rd_chk(8'h20, tab[i] & 8'h07);
      check(ctrl_v(), tab[i] & 8'h07);
    end

    // pins rule while override is clear, even with mode bits set
    for (int p = 0; p < 4; p++) begin
      pins(p[1], p[0]);
      check(mux_v(), {3'h0, p[1], 3'h0, p[0]});
    end
    wr(8'h21, 8'hFF);
    rd_chk(8'h21, 8'h13);
    pins(1'b0, 1'b0);
    check(mux_v(), 8'h00);
    wr(8'h22, 8'hFF);
    rd_chk(8'h22, 8'h11);
    check(mux_v(), 8'h11);
    // every mode code against pins both high
    pins(1'b1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(8'h21, {3'h0, m[0], 2'h0, m[1:0]});
      check(mux_v(), {3'h0, m[0], 3'h0, m[1] & m[0]});
    end
    wr(8'h22, 8'h00);
    pins(1'b1, 1'b0);
    check(mux_v(), 8'h10);

    // output drivers: free when bit 6 clear, else per enable bit
    tab = '{8'h80, 8'h40, 8'h60, 8'h50, 8'h48, 8'h44, 8'h42, 8'h41, 8'hBF};
    for (int i = 0; i < 9; i++) begin
      v = tab[i];
      wr(8'h27, v);
      rd_chk(8'h27, v);
      check(lvds_v(), {v[7], v[6] ? v[5] : 1'b1, 1'b0,
                       v[6] ? v[4:0] : 5'h1F});
    end

    // unmapped offset and a foreign address leave everything alone
    wr(8'h23, 8'hAA);
    rd_chk(8'h23, 8'h00);
    i_dcr_smbus_master.write_reg(DEV ^ 7'h01, 8'h20, 8'h07, ok);
    check({7'h00, ok}, 8'h00);
    check(ctrl_v(), 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
